// ==== hw/sts_cfg.svh ====
// Constants of the start-up sequencer: timing, counts, offsets, fields
`ifndef STS_CFG_SVH
`define STS_CFG_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define STS_PCLK_NS      20
`define STS_CLKIN_NS     200
`define STS_CLKIN_DIV    4'((`STS_CLKIN_NS) / (`STS_PCLK_NS))
`define STS_DIV_LAST     4'((`STS_CLKIN_DIV) - 4'h1)

// ----------------------------------------
// Sequence counts, in input clock periods
// ----------------------------------------
`define STS_WAIT_LAST    8'h8F
`define STS_SCAN_LAST    8'h8F
`define STS_CFG_LAST     6'h23
`define STS_RFSH_LAST    8'h07

// ----------------------------------------
// Memory configuration word fields
// ----------------------------------------
`define STS_CFG_RFSH_BIT 0
`define STS_CFG_DLY_LSB  4
`define STS_CFG_DLY_MSB  7
`define STS_MEM_DEPTH    64

// ----------------------------------------
// Register map
// ----------------------------------------
`define STS_ADDR_CTRL    12'h000
`define STS_ADDR_STATUS  12'h004
`define STS_ADDR_CFG     12'h008
`define STS_MEM_BASE     12'h100
`define STS_MEM_TOP      12'h18C
`define STS_CTRL_RST     1'b0
`define STS_CTRL_NORFSH  0
`define STS_STAT_ST_MSB  7
`define STS_STAT_FOUND   8
`define STS_STAT_RVALID  9
`define STS_STAT_BOOTROM 10
`define STS_STAT_MUL_LSB 16
`define STS_STAT_MUL_MSB 19

// ----------------------------------------
// Core rate multipliers, twice the input clock ratio
// ----------------------------------------
`define STS_MULT_200     4'h8
`define STS_MULT_225     4'h9
`define STS_MULT_250     4'hA
`define STS_MULT_300     4'hC
`define STS_MULT_350     4'hE
`define STS_MULT_175     4'h7
`define STS_MULT_NONE    4'h0

`endif

// ==== hw/sts_pkg.sv ====
// Types shared by the start-up sequencer files
package sts_pkg;
   typedef logic [31:0] sts_word_t;
   typedef logic [11:0] sts_addr_t;
   typedef logic [5:0]  sts_idx_t;
   typedef logic [3:0]  sts_mult_t;
   typedef logic [3:0]  sts_link_t;

   typedef enum logic [7:0]
   {
      ST_HOLD     = 8'h01,
      ST_WAIT     = 8'h02,
      ST_SCAN     = 8'h04,
      ST_CFGRD    = 8'h08,
      ST_CFGDLY   = 8'h10,
      ST_RFSH     = 8'h20,
      ST_BOOTROM  = 8'h40,
      ST_BOOTLINK = 8'h80
   } sts_state_e;
endpackage

// ==== hw/sts_cfg_mem.sv ====
// Store of the configuration read words, registered read port
`timescale 1ns/1ps
`include "sts_cfg.svh"
module sts_cfg_mem
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             we,
   input  wire sts_pkg::sts_idx_t waddr,
   input  wire sts_pkg::sts_word_t wdata,
   input  wire sts_pkg::sts_idx_t raddr,
   output sts_pkg::sts_word_t    rdata
);
   import sts_pkg::*;

   sts_word_t mem [`STS_MEM_DEPTH];

   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata <= '0;
      end
      else
      begin
         rdata <= mem[raddr];
      end
   end
endmodule

// ==== hw/sts_top.sv ====
// Start-up sequencer: reset sync, memory config sequence, boot, rate decode
`timescale 1ns/1ps
`include "sts_cfg.svh"
// Behaviour
// - Reset fall initialises state, runs memory configuration, then starts bootstrap.
// - Serial link outputs are held low while reset is asserted.
// - After reset release, wait 144 input clock periods.
// - Then scan write, refresh and bus pins for 144 more periods.
// - Then issue 36 configuration reads with the default configuration.
// - After a configuration-dependent delay, run eight back-to-back refresh cycles.
// - With refresh disabled, an equal idle delay replaces the refresh cycles.
// - Boot select high boots from memory at once, else waits for links.
// - Bootstrap begins in the low priority state.
// - Rate select 000..100,110 gives 20, 22.5, 25, 30, 35, 17.5 MHz.
// - Rate select 101 and 111 are invalid.
// - Fast core clocks come from multiplying the input clock.
// - Boot select is sampled once per reset release.
// - Links accept a first byte within two core cycles of reset fall.
module sts_top
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire sts_pkg::sts_addr_t paddr,
   input  wire sts_pkg::sts_word_t pwdata,
   output sts_pkg::sts_word_t     prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              reset_in,
   input  wire logic              boot_source_select,
   input  wire logic [2:0]        core_rate_select,
   input  wire logic              mem_write_strobe_data0,
   input  wire logic              mem_refresh_strobe_data1,
   input  wire logic [29:0]       mem_multiplexed_bus_upper,
   input  wire sts_pkg::sts_word_t mem_cfg_rdata,
   output logic                   mem_cfg_read,
   output sts_pkg::sts_idx_t      mem_cfg_index,
   output logic                   mem_refresh_cycle,
   input  wire sts_pkg::sts_link_t link_tx_core,
   output sts_pkg::sts_link_t     link_out,
   output logic                   link_rx_ready,
   output logic                   boot_rom_start,
   output logic                   boot_link_wait,
   output logic                   low_priority,
   output sts_pkg::sts_mult_t     core_mult_x2,
   output logic                   rate_valid
);
   import sts_pkg::*;

   sts_state_e st;
   sts_state_e next_state;
   logic       rst_q1;
   logic       rst_sync;
   logic       rst_d3;
   logic       rst_fall;
   logic [3:0] div;
   logic       tick;
   logic [7:0] cnt;
   logic       cfg_found;
   sts_word_t  scan_word;
   sts_word_t  first_word;
   sts_word_t  cfg_word;
   logic       ctrl_norfsh;
   logic       rfsh_en;
   logic       boot_sel_q;
   sts_link_t  link_q;
   logic       access;
   logic       ack_q;
   logic       hit_ctrl;
   logic       hit_stat;
   logic       hit_cfg;
   logic       hit_mem;
   sts_word_t  status;
   sts_word_t  mem_rdata;
   logic [7:0] dly_last;

   // ----------------------------------------
   // Reset pin synchroniser and edge detect
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rst_q1   <= 1'b1;
         rst_sync <= 1'b1;
         rst_d3   <= 1'b1;
      end
      else
      begin
         rst_q1   <= reset_in;
         rst_sync <= rst_q1;
         rst_d3   <= rst_sync;
      end
   end

   assign rst_fall = rst_d3 & ~rst_sync;

   // ----------------------------------------
   // Input clock period enable
   // ----------------------------------------
   // Restarted by reset so every count starts on a clean period
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div <= 4'h0;
      end
      else if (rst_sync || tick)
      begin
         div <= 4'h0;
      end
      else
      begin
         div <= div + 4'h1;
      end
   end

   assign tick = (div == `STS_DIV_LAST);

   // ----------------------------------------
   // Sequence state machine
   // ----------------------------------------
   assign rfsh_en  = cfg_word[`STS_CFG_RFSH_BIT] & ~ctrl_norfsh;
   assign dly_last = 8'(cfg_word[`STS_CFG_DLY_MSB:`STS_CFG_DLY_LSB]);

   always_comb
   begin
      next_state = st;
      unique case (st)
         ST_HOLD:
         begin
            if (rst_fall)
               next_state = ST_WAIT;
         end
         ST_WAIT:
         begin
            if (tick && cnt == `STS_WAIT_LAST)
               next_state = ST_SCAN;
         end
         ST_SCAN:
         begin
            if (tick && cnt == `STS_SCAN_LAST)
               next_state = ST_CFGRD;
         end
         ST_CFGRD:
         begin
            if (tick && mem_cfg_index == `STS_CFG_LAST)
               next_state = ST_CFGDLY;
         end
         ST_CFGDLY:
         begin
            if (tick && cnt == dly_last)
               next_state = ST_RFSH;
         end
         ST_RFSH:
         begin
            if (tick && cnt == `STS_RFSH_LAST)
               next_state = boot_source_select ? ST_BOOTROM : ST_BOOTLINK;
         end
         ST_BOOTROM:
         begin
            next_state = ST_BOOTROM;
         end
         ST_BOOTLINK:
         begin
            next_state = ST_BOOTLINK;
         end
      endcase
      if (rst_sync)
         next_state = ST_HOLD;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st <= ST_HOLD;
      end
      else
      begin
         st <= next_state;
      end
   end

   // Period counter, restarted on every state change
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt <= 8'h00;
      end
      else if (next_state != st)
      begin
         cnt <= 8'h00;
      end
      else if (tick)
      begin
         cnt <= cnt + 8'h01;
      end
   end

   // ----------------------------------------
   // Pin scan and configuration choice
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg_found <= 1'b0;
         scan_word <= '0;
      end
      else if (rst_sync)
      begin
         cfg_found <= 1'b0;
         scan_word <= '0;
      end
      else if (st == ST_SCAN && tick &&
               ({mem_multiplexed_bus_upper, mem_refresh_strobe_data1,
                 mem_write_strobe_data0} != '0))
      begin
         cfg_found <= 1'b1;
         scan_word <= {mem_multiplexed_bus_upper, mem_refresh_strobe_data1,
                       mem_write_strobe_data0};
      end
   end

   // Reads run regardless of a scan hit; the hit takes precedence
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mem_cfg_index <= '0;
         first_word    <= '0;
         cfg_word      <= '0;
      end
      else if (rst_sync)
      begin
         mem_cfg_index <= '0;
      end
      else if (st == ST_CFGRD && tick)
      begin
         mem_cfg_index <= mem_cfg_index + 6'h01;
         if (mem_cfg_index == '0)
            first_word <= mem_cfg_rdata;
         if (next_state == ST_CFGDLY)
            cfg_word <= cfg_found ? scan_word : first_word;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mem_cfg_read <= 1'b0;
      end
      else
      begin
         mem_cfg_read <= (next_state == ST_CFGRD);
      end
   end

   sts_cfg_mem u_mem
   (
      .clk   (pclk),
      .rst_n (presetn),
      .we    (st == ST_CFGRD && tick),
      .waddr (mem_cfg_index),
      .wdata (mem_cfg_rdata),
      .raddr (paddr[7:2]),
      .rdata (mem_rdata)
   );

   // ----------------------------------------
   // Refresh burst or equivalent idle
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mem_refresh_cycle <= 1'b0;
      end
      else
      begin
         mem_refresh_cycle <= (next_state == ST_RFSH) && rfsh_en;
      end
   end

   // ----------------------------------------
   // Boot hand-over
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         boot_sel_q     <= 1'b0;
         boot_rom_start <= 1'b0;
         boot_link_wait <= 1'b0;
      end
      else
      begin
         if (rst_sync)
            boot_sel_q <= 1'b0;
         else if (st == ST_RFSH && next_state != ST_RFSH)
            boot_sel_q <= boot_source_select;
         boot_rom_start <= (st == ST_RFSH) && (next_state == ST_BOOTROM);
         boot_link_wait <= (next_state == ST_BOOTLINK);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         low_priority  <= 1'b0;
         link_rx_ready <= 1'b0;
      end
      else if (rst_sync)
      begin
         low_priority  <= 1'b0;
         link_rx_ready <= 1'b0;
      end
      else if (rst_fall)
      begin
         low_priority  <= 1'b1;
         link_rx_ready <= 1'b1;
      end
   end

   // ----------------------------------------
   // Link outputs
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         link_q <= '0;
      end
      else
      begin
         link_q <= rst_sync ? '0 : link_tx_core;
      end
   end

   // Raw pin also gates, so no link glitch during the sync delay
   assign link_out = link_q & {4{~reset_in}};

   // ----------------------------------------
   // Core rate decode
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         core_mult_x2 <= `STS_MULT_NONE;
         rate_valid   <= 1'b0;
      end
      else
      begin
         rate_valid <= 1'b1;
         unique case (core_rate_select)
            3'h0: core_mult_x2 <= `STS_MULT_200;
            3'h1: core_mult_x2 <= `STS_MULT_225;
            3'h2: core_mult_x2 <= `STS_MULT_250;
            3'h3: core_mult_x2 <= `STS_MULT_300;
            3'h4: core_mult_x2 <= `STS_MULT_350;
            3'h6: core_mult_x2 <= `STS_MULT_175;
            default:
            begin
               core_mult_x2 <= `STS_MULT_NONE;
               rate_valid   <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // APB slave, one wait state on every access
   // ----------------------------------------
   assign access   = psel & penable;
   assign hit_ctrl = (paddr == `STS_ADDR_CTRL);
   assign hit_stat = (paddr == `STS_ADDR_STATUS);
   assign hit_cfg  = (paddr == `STS_ADDR_CFG);
   assign hit_mem  = (paddr >= `STS_MEM_BASE) && (paddr <= `STS_MEM_TOP) &&
                     (paddr[1:0] == 2'b00);
   assign pready   = access & ack_q;
   assign pslverr  = pready & ~(hit_ctrl | hit_stat | hit_cfg | hit_mem);

   always_comb
   begin
      status = '0;
      status[`STS_STAT_ST_MSB:0] = st;
      status[`STS_STAT_FOUND]   = cfg_found;
      status[`STS_STAT_RVALID]  = rate_valid;
      status[`STS_STAT_BOOTROM] = boot_sel_q;
      status[`STS_STAT_MUL_MSB:`STS_STAT_MUL_LSB] = core_mult_x2;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ack_q  <= 1'b0;
         prdata <= '0;
      end
      else
      begin
         ack_q <= access & ~ack_q;
         if (access && !ack_q)
         begin
            if (hit_ctrl)
               prdata <= {31'h0, ctrl_norfsh};
            else if (hit_stat)
               prdata <= status;
            else if (hit_cfg)
               prdata <= cfg_word;
            else if (hit_mem)
               prdata <= mem_rdata;
            else
               prdata <= '0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_norfsh <= `STS_CTRL_RST;
      end
      else if (pready && pwrite && hit_ctrl)
      begin
         ctrl_norfsh <= pwdata[`STS_CTRL_NORFSH];
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence fall_s;
      rst_d3 && !rst_sync;
   endsequence
   sequence leave_wait_s;
      st == ST_WAIT ##1 st == ST_SCAN;
   endsequence
   sequence leave_scan_s;
      st == ST_SCAN ##1 st == ST_CFGRD;
   endsequence
   sequence leave_rfsh_s;
      st == ST_RFSH ##1 (st == ST_BOOTROM || st == ST_BOOTLINK);
   endsequence

   link_low_a: assert property (reset_in |-> link_out == '0)
      else $error("link output not low in reset");
   wait_len_a: assert property (leave_wait_s |-> $past(cnt) == `STS_WAIT_LAST)
      else $error("initial wait not 144 periods");
   scan_len_a: assert property (leave_scan_s |-> $past(cnt) == `STS_SCAN_LAST)
      else $error("scan not 144 periods");
   cfg_reads_a: assert property (st == ST_CFGRD ##1 st == ST_CFGDLY
      |-> $past(mem_cfg_index) == `STS_CFG_LAST)
      else $error("config read count wrong");
   rfsh_len_a: assert property (leave_rfsh_s |-> $past(cnt) == `STS_RFSH_LAST)
      else $error("refresh burst not eight cycles");
   rfsh_idle_a: assert property (next_state == ST_RFSH && !rfsh_en
      |=> !mem_refresh_cycle)
      else $error("refresh with refresh disabled");
   boot_rom_a: assert property ($rose(boot_rom_start)
      |-> boot_sel_q && st == ST_BOOTROM)
      else $error("rom boot without select");
   boot_link_a: assert property (boot_link_wait |-> !boot_sel_q)
      else $error("link wait with rom select");
   boot_prio_a: assert property (st == ST_BOOTROM || st == ST_BOOTLINK
      |-> low_priority)
      else $error("boot not in low priority");
   rate_dec_a: assert property (core_rate_select == 3'h6
      |=> core_mult_x2 == `STS_MULT_175 && rate_valid)
      else $error("rate 110 decode wrong");
   rate_bad_a: assert property (core_rate_select[2] && core_rate_select[0]
      |=> !rate_valid)
      else $error("invalid rate accepted");
   link_rdy_a: assert property (fall_s |-> ##[1:2] link_rx_ready)
      else $error("link not ready after reset fall");
   rst_sync_a: assert property ($rose(reset_in) ##1 reset_in
      |-> ##1 rst_sync)
      else $error("reset not synchronised in two cycles");
endmodule

// ==== bench/sts_mem_model.sv ====
// Behavioural external memory and strapped memory pins facing the sequencer
`timescale 1ns/1ps
module sts_mem_model
(
   input  wire logic               pclk,
   input  wire logic               mem_cfg_read,
   input  wire sts_pkg::sts_idx_t  mem_cfg_index,
   input  wire sts_pkg::sts_word_t scan_word,
   input  wire sts_pkg::sts_word_t word0,
   output sts_pkg::sts_word_t      mem_cfg_rdata,
   output logic                    mem_write_strobe_data0,
   output logic                    mem_refresh_strobe_data1,
   output logic [29:0]             mem_multiplexed_bus_upper
);
   import sts_pkg::*;
   sts_word_t churn = 32'h5A5A_5A5A;

   // ----------------------------------------
   // Pins and store
   // ----------------------------------------
   // Preset configuration held on the strapped pins
   assign {mem_multiplexed_bus_upper, mem_refresh_strobe_data1, mem_write_strobe_data0} = scan_word;

   // Released bus keeps changing, so a stale word is never read by luck
   always_ff @(posedge pclk)
   begin
      churn <= ~churn + 32'h0000_0001;
   end

   // Word 0 set by the bench, the rest tagged with their index
   // No memory, link or event request is raised from this side
   always_comb
   begin
      if (!mem_cfg_read)
         mem_cfg_rdata = churn;
      else if (mem_cfg_index == 6'h00)
         mem_cfg_rdata = word0;
      else
         mem_cfg_rdata = 32'hA500_0000 | {26'h0, mem_cfg_index};
   end
endmodule

// ==== bench/test_startup_sequencer.sv ====
// Self-checking bench of the start-up sequencer
`timescale 1ns/1ps
`include "sts_cfg.svh"
module test_startup_sequencer;
   import sts_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   sts_addr_t   paddr = 12'h000;
   sts_word_t   pwdata = 32'h0000_0000;
   logic        reset_in = 1'b1;
   logic        boot_source_select = 1'b0;
   logic [2:0]  core_rate_select = 3'h0;
   sts_link_t   link_tx_core = 4'hF;
   sts_word_t   scan_word = 32'h0000_0000;
   sts_word_t   word0 = 32'h0000_0000;
   sts_word_t   prdata, mem_cfg_rdata;
   logic        pready, pslverr, mem_write_strobe_data0, mem_refresh_strobe_data1;
   logic [29:0] mem_multiplexed_bus_upper;
   logic        mem_cfg_read, mem_refresh_cycle, link_rx_ready, boot_rom_start;
   logic        boot_link_wait, low_priority, rate_valid;
   sts_idx_t    mem_cfg_index;
   sts_link_t   link_out;
   sts_mult_t   core_mult_x2;
   int          n_fail = 0;
   int          num_checks = 0;

   // Ten periods to one 5 MHz input clock period
   always #10 pclk = ~pclk;

   sts_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .reset_in, .boot_source_select, .core_rate_select,
      .mem_write_strobe_data0, .mem_refresh_strobe_data1, .mem_multiplexed_bus_upper,
      .mem_cfg_rdata, .mem_cfg_read, .mem_cfg_index, .mem_refresh_cycle, .link_tx_core,
      .link_out, .link_rx_ready, .boot_rom_start, .boot_link_wait, .low_priority,
      .core_mult_x2, .rate_valid);

   sts_mem_model mem (.pclk, .mem_cfg_read, .mem_cfg_index, .scan_word, .word0,
      .mem_cfg_rdata, .mem_write_strobe_data0, .mem_refresh_strobe_data1,
      .mem_multiplexed_bus_upper);

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic bound(input int n, input int lim);
      if (n >= lim)
      begin
         n_fail++;
         $display("FAIL %0t wait ran out", $time);
         test_done();
      end
   endtask

   task automatic step();
      @(posedge pclk);
      #1;
   endtask

   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input sts_addr_t a, input sts_word_t wd,
                      output sts_word_t rd, output logic err);
      int   n;
      logic ok;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         #1;
         ok = pready;
         rd = prdata;
         err = pslverr;
         @(posedge pclk);
         n++;
      end
      while (ok !== 1'b1 && n < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      bound(n, 20);
   endtask

   // One full start-up run; all figures in pclk cycles, ten to a tick
   task automatic run_seq(input sts_word_t sw, input sts_word_t c0, input logic boot,
                          input logic nr);
      int        n;
      int        m;
      int        d;
      int        rc;
      int        r0;
      sts_word_t cf;
      sts_word_t rd;
      logic      er;
      n = 0;
      rc = 0;
      r0 = 0;
      cf = (sw != 32'h0) ? sw : c0;
      d = (int'(cf[7:4]) + 1) * 10;
      apb(1'b1, `STS_ADDR_CTRL, {31'h0, nr}, rd, er);
      @(posedge pclk);
      scan_word <= sw;
      word0 <= c0;
      boot_source_select <= boot;
      reset_in <= 1'b1;
      repeat (8) step();
      @(posedge pclk);
      reset_in <= 1'b0;
      while (link_rx_ready !== 1'b1 && n < 10)
      begin
         step();
         n++;
      end
      chk(32'(n <= 4), 32'h1);
      chk({31'h0, low_priority}, 32'h1);
      while (mem_cfg_read !== 1'b1 && n < 4000)
      begin
         step();
         n++;
      end
      bound(n, 4000);
      chk(32'(n >= 32'hB40 && n <= 32'hB50), 32'h1);
      chk({26'h0, mem_cfg_index}, 32'h0);
      m = n;
      while (mem_cfg_read === 1'b1 && n < 5000)
      begin
         step();
         n++;
      end
      chk(32'(n - m), 32'h168);
      m = n;
      while (boot_rom_start !== 1'b1 && boot_link_wait !== 1'b1 && n < 9000)
      begin
         if (mem_refresh_cycle === 1'b1)
         begin
            if (rc == 0)
               r0 = n - m;
            rc++;
         end
         step();
         n++;
      end
      bound(n, 9000);
      chk(32'(n - m >= d + 80 && n - m <= d + 82), 32'h1);
      chk(32'(rc), (cf[0] && !nr) ? 32'h50 : 32'h0);
      chk(32'(!cf[0] || nr || (r0 >= d && r0 <= d + 1)), 32'h1);
      chk({31'h0, boot_rom_start}, {31'h0, boot});
      chk({31'h0, boot_link_wait}, {31'h0, !boot});
      chk({31'h0, low_priority}, 32'h1);
      chk({28'h0, link_out}, 32'h0000_000F);
      step();
      chk({31'h0, boot_rom_start}, 32'h0);
      apb(1'b0, `STS_ADDR_STATUS, 32'h0, rd, er);
      chk({21'h0, rd[10:0]}, {21'h0, boot, 1'b1, sw != 32'h0, boot ? ST_BOOTROM : ST_BOOTLINK});
      apb(1'b0, `STS_ADDR_CFG, 32'h0, rd, er);
      chk(rd, cf);
      for (int i = 0; i < 36; i++)
      begin
         apb(1'b0, `STS_MEM_BASE + 12'(4 * i), 32'h0, rd, er);
         chk(rd, (i == 0) ? c0 : (32'hA500_0000 | 32'(i)));
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      sts_word_t rd;
      logic      er;
      apb(1'b0, `STS_ADDR_CTRL, 32'h0, rd, er);
      chk(rd, 32'h0);
      apb(1'b1, `STS_ADDR_CTRL, 32'h0000_0001, rd, er);
      apb(1'b0, `STS_ADDR_CTRL, 32'h0, rd, er);
      chk(rd, 32'h0000_0001);
      chk({31'h0, er}, 32'h0);
      apb(1'b1, `STS_ADDR_CTRL, 32'h0, rd, er);
      apb(1'b0, 12'h050, 32'h0, rd, er);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
   endtask

   task automatic t_rate();
      logic [3:0] tbl [8] = '{4'h8, 4'h9, 4'hA, 4'hC, 4'hE, 4'h0, 4'h7, 4'h0};
      for (int i = 0; i < 8; i++)
      begin
         @(posedge pclk);
         // Strap moved only while reset_in holds the device
         core_rate_select <= 3'(i);
         repeat (3) step();
         chk({28'h0, core_mult_x2}, {28'h0, tbl[i]});
         chk({31'h0, rate_valid}, {31'h0, tbl[i] != 4'h0});
         chk({28'h0, link_out}, 32'h0);
      end
      @(posedge pclk);
      core_rate_select <= 3'h0;
   endtask

   task automatic t_boot_link();
      run_seq(32'h0000_0000, 32'h0000_0050, 1'b0, 1'b0);
      @(posedge pclk);
      boot_source_select <= 1'b1;
      repeat (20)
      begin
         step();
         chk({30'h0, boot_rom_start, boot_link_wait}, 32'h1);
      end
   endtask

   task automatic t_abort();
      int        n;
      sts_word_t rd;
      logic      er;
      n = 0;
      // Device sits booted with reset_in low; a fresh fall is needed
      @(posedge pclk);
      reset_in <= 1'b1;
      repeat (8) step();
      @(posedge pclk);
      reset_in <= 1'b0;
      while (mem_cfg_read !== 1'b1 && n < 4000)
      begin
         step();
         n++;
      end
      bound(n, 4000);
      @(posedge pclk);
      reset_in <= 1'b1;
      repeat (4) step();
      chk({31'h0, mem_cfg_read}, 32'h0);
      chk({30'h0, link_rx_ready, low_priority}, 32'h0);
      chk({28'h0, link_out}, 32'h0);
      apb(1'b0, `STS_ADDR_STATUS, 32'h0, rd, er);
      chk({24'h0, rd[7:0]}, {24'h0, ST_HOLD});
   endtask

   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_rate();
      run_seq(32'h0000_0031, 32'h0000_00F0, 1'b1, 1'b0);
      run_seq(32'h0000_0000, 32'h0000_0021, 1'b1, 1'b1);
      t_boot_link();
      t_abort();
      test_done();
   end
endmodule
